// ### lpac_top.sv
// Summary of operation
// RL1: read-only 16-bit partner ability word at register index 0x05.
// RL2: after successful negotiation with next pages, show the next-page layout.
// RL3: bit 15 shows the partner's next page request in both layouts.
// RL4: bit 14 partner acknowledge, updated only by the negotiation machine.
// RL5: software should never write the acknowledge bit.
// RL6: base bit 13 shows the partner's remote fault.
// RL7: base bit 12 reserved, reads zero; software writes zero.
// RL8: bit 11 asymmetric pause, bit 10 symmetric pause ability.
// RL9: bit 9 shows partner four-pair 100 Mb/s ability.
// RL10: bits 8..5 show partner 100 full, 100, 10 full, 10 abilities.
// RL11: bits 4:0 hold partner selector; reset value zero.
// RL12: next layout bit 13 message page flag, bits 10:0 code.
// RL13: next layout bit 12 comply ability, bit 11 toggle.
// RL14: each capture sets page-received in expansion status; reading clears it.
// RL15: writes to the partner ability register are ignored.
// RL16: captured fields are zero after reset until a word arrives.
//
// Register access over AHB-Lite was chosen for this implementation.
`include "lpac_defines.svh"

module lpac_top
  import lpac_pkg::*;
(
  input wire logic hclk,               // device clock, 100 MHz
  input wire logic hresetn,            // async reset, active low
  input wire logic hsel,               // slave select
  input wire logic [31:0] haddr,       // byte address
  input wire logic [1:0] htrans,       // transfer type
  input wire logic hwrite,             // write when high
  input wire logic [2:0] hsize,        // transfer size, word only
  input wire logic [2:0] hburst,       // burst type, singles only
  input wire logic [3:0] hprot,        // protection, unused
  input wire logic hready,             // bus ready in
  input wire logic [31:0] hwdata,      // write data
  output logic hreadyout,              // slave ready out
  output logic hresp,                  // response, always okay
  output logic [31:0] hrdata,          // read data
  input wire logic an_word_valid,      // one-cycle pulse: partner word decoded
  input wire logic [15:0] an_word,     // partner code word
  input wire logic an_word_is_next,    // word belongs to a next page
  input wire logic an_complete,        // negotiation finished, level
  input wire logic next_pages_supported // both ends exchange next pages
);

  lpac_cap_if cap_bus ();

  // address phase capture
  logic addr_ok_w;
  logic [7:0] addr_idx_w;
  logic wr_pend_r;
  logic [7:0] wr_idx_r;

  // register state
  logic capture_en_r;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;

  // shown layout
  lpac_view_t view_w;
  logic [15:0] partner_word_w;

  // decode a byte address into a register index; misaligned or out of range
  // addresses fold onto one index that nothing claims
  function automatic logic [7:0] lpac_word_index(input logic [31:0] addr);
    logic [7:0] idx;
    idx = addr[`LPAC_ADDR_IDX_MSB:`LPAC_ADDR_IDX_LSB];
    if (addr[31:`LPAC_ADDR_IDX_MSB + 1] != 22'h000000)
      idx = `LPAC_IDX_UNMAPPED;
    else if (addr[`LPAC_ADDR_IDX_LSB - 1:0] != 2'h0)
      idx = `LPAC_IDX_UNMAPPED;
    return idx;
  endfunction : lpac_word_index

  // the slave never inserts wait states and never errors
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_r;

  // a transfer is taken when selected, nonseq or seq, and the bus is ready
  assign addr_ok_w = hsel & htrans[1] & hready;
  assign addr_idx_w = lpac_word_index(haddr);

  // connections towards the capture store; same clock, so no synchroniser
  assign cap_bus.cap_valid = an_word_valid;
  assign cap_bus.cap_word = an_word;
  assign cap_bus.cap_is_next = an_word_is_next;
  assign cap_bus.capture_en = capture_en_r;

  // a read of expansion status clears the page received flag in the same
  // edge that loads the read data, so the read still sees the old value
  assign cap_bus.clear_page_rx = addr_ok_w & ~hwrite & (addr_idx_w == `LPAC_IDX_EXPANSION); // RL14

  lpac_capture u_capture (
    .hclk(hclk),
    .hresetn(hresetn),
    .cap(cap_bus.capture)
  );

  // the next-page layout is only shown once negotiation is done, both ends
  // use next pages and one has actually arrived; before that the base page
  always_comb
  begin
    if (an_complete && next_pages_supported && cap_bus.next_seen)
      view_w = LPAC_VIEW_NEXT; // RL2
    else
      view_w = LPAC_VIEW_BASE;
  end

  lpac_view_format u_format (
    .base_word(cap_bus.base_word),
    .next_word(cap_bus.next_word),
    .view(view_w),
    .word(partner_word_w)
  );

  // write data arrives one cycle after its address; keep the target index
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_r <= 1'b0;
      wr_idx_r <= `LPAC_IDX_UNMAPPED;
    end
    else if (hready)
    begin
      wr_pend_r <= addr_ok_w & hwrite;
      wr_idx_r <= addr_idx_w;
    end
  end

  // control register: only the capture enable is writable; writes to the
  // partner word, expansion and status indices fall through untouched, which
  // also keeps the acknowledge bit out of software's reach
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      capture_en_r <= `LPAC_CTRL_RESET;
    else if (wr_pend_r && (wr_idx_r == `LPAC_IDX_CTRL))
      capture_en_r <= hwdata[`LPAC_CTRL_CAPTURE_EN_BIT];
    else if (wr_pend_r && (wr_idx_r == `LPAC_IDX_PARTNER))
      capture_en_r <= capture_en_r; // RL15 RL5
  end

  // read multiplexer; narrow registers sit in the low bits, the rest zero
  always_comb
  begin
    rdata_nxt = 32'h00000000;
    if (addr_idx_w == `LPAC_IDX_PARTNER)
      rdata_nxt[15:0] = partner_word_w; // RL1
    else if (addr_idx_w == `LPAC_IDX_EXPANSION)
      rdata_nxt[`LPAC_EXP_PAGE_RX_BIT] = cap_bus.page_rx; // RL14
    else if (addr_idx_w == `LPAC_IDX_CTRL)
      rdata_nxt[`LPAC_CTRL_CAPTURE_EN_BIT] = capture_en_r;
    else if (addr_idx_w == `LPAC_IDX_STAT)
    begin
      rdata_nxt[`LPAC_STAT_VIEW_BIT] = view_w;
      rdata_nxt[`LPAC_STAT_AN_DONE_BIT] = an_complete;
      rdata_nxt[`LPAC_STAT_NEXT_SEEN_BIT] = cap_bus.next_seen;
      rdata_nxt[`LPAC_STAT_COUNT_MSB:`LPAC_STAT_COUNT_LSB] = cap_bus.cap_count;
    end
  end

  // read data is loaded at the address edge and stands in the data phase;
  // a capture in that same edge shows on the next read, not this one
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      rdata_r <= 32'h00000000;
    else if (addr_ok_w && !hwrite)
      rdata_r <= rdata_nxt;
  end

endmodule : lpac_top

// ### lpac_defines.svh
`ifndef LPAC_DEFINES_SVH
`define LPAC_DEFINES_SVH

// register indices; byte address is four times the index
`define LPAC_IDX_PARTNER 8'h05
`define LPAC_IDX_EXPANSION 8'h06
`define LPAC_IDX_CTRL 8'h10
`define LPAC_IDX_STAT 8'h11
`define LPAC_IDX_UNMAPPED 8'hff

// byte address split: index bits and the upper bits that must be zero
`define LPAC_ADDR_IDX_LSB 2
`define LPAC_ADDR_IDX_MSB 9

// expansion status field
`define LPAC_EXP_PAGE_RX_BIT 1

// control register fields and reset values
`define LPAC_CTRL_CAPTURE_EN_BIT 0
`define LPAC_CTRL_RESET 1'b1

// status register fields
`define LPAC_STAT_VIEW_BIT 0
`define LPAC_STAT_AN_DONE_BIT 1
`define LPAC_STAT_NEXT_SEEN_BIT 2
`define LPAC_STAT_COUNT_LSB 8
`define LPAC_STAT_COUNT_MSB 15

// captured word reset value
`define LPAC_WORD_RESET 16'h0000
`define LPAC_SELECTOR_RESET 5'h00

`endif

// ### lpac_pkg.sv
package lpac_pkg;

  // which layout the partner ability word is shown in
  typedef enum logic [0:0] {
    LPAC_VIEW_BASE = 1'b0,
    LPAC_VIEW_NEXT = 1'b1
  } lpac_view_t;

  // base page as received from the partner
  typedef struct packed {
    logic next_page_request;
    logic partner_ack;
    logic remote_fault_flag;
    logic reserved;
    logic asymmetric_pause_ability;
    logic pause_ability;
    logic four_pair_fast_ability;
    logic fast_full_duplex_ability;
    logic fast_ability;
    logic ten_full_duplex_ability;
    logic ten_ability;
    logic [4:0] selector;
  } lpac_base_page_t;

  // next page as received from the partner
  typedef struct packed {
    logic next_page_request;
    logic partner_ack;
    logic message_page_flag;
    logic partner_comply_ability;
    logic toggle;
    logic [10:0] code;
  } lpac_next_page_t;

endpackage : lpac_pkg

// ### lpac_cap_if.sv
interface lpac_cap_if;
  import lpac_pkg::*;

  logic cap_valid;
  logic [15:0] cap_word;
  logic cap_is_next;
  logic capture_en;
  logic clear_page_rx;
  lpac_base_page_t base_word;
  lpac_next_page_t next_word;
  logic next_seen;
  logic page_rx;
  logic [7:0] cap_count;

  modport capture (
    input cap_valid, cap_word, cap_is_next, capture_en, clear_page_rx,
    output base_word, next_word, next_seen, page_rx, cap_count
  );
  modport owner (
    output cap_valid, cap_word, cap_is_next, capture_en, clear_page_rx,
    input base_word, next_word, next_seen, page_rx, cap_count
  );
endinterface : lpac_cap_if

// ### lpac_capture.sv
`include "lpac_defines.svh"

module lpac_capture
  import lpac_pkg::*;
(
  input wire logic hclk,           // device clock
  input wire logic hresetn,        // async reset, active low
  lpac_cap_if.capture cap          // capture requests and held words
);

  logic take_w;

  assign take_w = cap.cap_valid & cap.capture_en;

  // base page store; only the negotiation machine ever loads it
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      cap.base_word <= lpac_base_page_t'(`LPAC_WORD_RESET); // RL16 RL11
    else if (take_w && !cap.cap_is_next)
    begin
      cap.base_word <= lpac_base_page_t'(cap.cap_word); // RL1 RL4
      cap.base_word.reserved <= 1'b0; // RL7
    end
  end

  // next page store
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      cap.next_word <= lpac_next_page_t'(`LPAC_WORD_RESET); // RL16
    else if (take_w && cap.cap_is_next)
      cap.next_word <= lpac_next_page_t'(cap.cap_word); // RL2 RL4
  end

  // a fresh base page starts a new exchange, so any old next page is stale
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      cap.next_seen <= 1'b0;
    else if (take_w)
      cap.next_seen <= cap.cap_is_next;
  end

  // page received flag: a capture in the clearing cycle wins
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      cap.page_rx <= 1'b0;
    else
      cap.page_rx <= take_w | (cap.page_rx & ~cap.clear_page_rx); // RL14
  end

  // count of captured words, wraps
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      cap.cap_count <= 8'h00;
    else if (take_w)
      cap.cap_count <= cap.cap_count + 8'h01;
  end

endmodule : lpac_capture

// ### lpac_view_format.sv
module lpac_view_format
  import lpac_pkg::*;
(
  input lpac_base_page_t base_word,   // held base page
  input lpac_next_page_t next_word,   // held next page
  input lpac_view_t view,             // layout to show
  output logic [15:0] word            // formatted partner ability word
);

  // place every field at its bit; reserved base bit always reads zero
  always_comb
  begin
    word = 16'h0000;
    if (view == LPAC_VIEW_NEXT)
    begin
      word[15] = next_word.next_page_request; // RL3
      word[14] = next_word.partner_ack; // RL4
      word[13] = next_word.message_page_flag; // RL12
      word[12] = next_word.partner_comply_ability; // RL13
      word[11] = next_word.toggle; // RL13
      word[10:0] = next_word.code; // RL12
    end
    else
    begin
      word[15] = base_word.next_page_request; // RL3
      word[14] = base_word.partner_ack; // RL4
      word[13] = base_word.remote_fault_flag; // RL6
      word[12] = 1'b0; // RL7
      word[11] = base_word.asymmetric_pause_ability; // RL8
      word[10] = base_word.pause_ability; // RL8
      word[9] = base_word.four_pair_fast_ability; // RL9
      word[8] = base_word.fast_full_duplex_ability; // RL10
      word[7] = base_word.fast_ability; // RL10
      word[6] = base_word.ten_full_duplex_ability; // RL10
      word[5] = base_word.ten_ability; // RL10
      word[4:0] = base_word.selector; // RL11
    end
  end

endmodule : lpac_view_format

// ### lpac_link_partner.sv
module lpac_link_partner (
  input wire logic hclk,        // device clock
  output logic an_word_valid,   // one-cycle word pulse
  output logic [15:0] an_word,  // partner code word
  output logic an_word_is_next  // page kind
);
  initial
  begin
    an_word_valid = 1'b0;
    an_word = 16'h0000;
    an_word_is_next = 1'b0;
  end
  // one word per call; off the pulse the word is inverted so a late sample shows up
  task send(input logic [15:0] w, input logic nxt);
    an_word_valid <= 1'b1;
    an_word <= w;
    an_word_is_next <= nxt;
    @(posedge hclk);
    an_word_valid <= 1'b0;
    an_word <= ~w;
    an_word_is_next <= ~nxt;
  endtask : send
endmodule : lpac_link_partner

// ### lpac_top_assertions.sv
module lpac_top_checker (
  input wire logic hclk,                // clock
  input wire logic hresetn,             // reset, active low
  input wire logic hsel,                // select
  input wire logic [31:0] haddr,        // address
  input wire logic [1:0] htrans,        // transfer type
  input wire logic hwrite,              // write
  input wire logic hready,              // ready in
  input wire logic hreadyout,           // ready out
  input wire logic hresp,               // response
  input wire logic [31:0] hrdata,       // read data
  input wire logic [31:0] hwdata,       // write data
  input wire logic an_word_valid,       // capture pulse
  input wire logic [15:0] an_word,      // partner word
  input wire logic an_word_is_next,     // next page
  input wire logic an_complete,         // negotiation done
  input wire logic next_pages_supported // next pages in use
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic seen_r;
  logic en_r;
  logic wr40_r;
  wire rd = hsel && htrans[1] && hready && !hwrite;
  wire rd14 = rd && haddr == 32'h14;
  wire rd18 = rd && haddr == 32'h18;
  wire wr14 = hsel && htrans[1] && hready && hwrite && haddr == 32'h14;
  wire unm = haddr != 32'h14 && haddr != 32'h18 && haddr != 32'h40 && haddr != 32'h44;
  // a read before any capture must see zero, so remember captures since reset
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      seen_r <= 1'b0;
    else if (an_word_valid)
      seen_r <= 1'b1;
  end
  // mirror of the capture enable; a word offered while it is off must not be expected in the store
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr40_r <= 1'b0;
      en_r <= 1'b1;
    end
    else
    begin
      wr40_r <= hsel && htrans[1] && hready && hwrite && haddr == 32'h40;
      if (wr40_r)
        en_r <= hwdata[0];
    end
  end
  sequence s_base_cap; an_word_valid && en_r && !an_word_is_next; endsequence
  sequence s_next_cap; an_word_valid && en_r && an_word_is_next && an_complete && next_pages_supported; endsequence
  a_ready_okay: assert property (hreadyout && !hresp) else $error("bus not ready or not okay");
  a_base_word: assert property ((s_base_cap ##1 rd14) |=> hrdata == {16'h0000, $past(an_word, 2) & 16'hefff})
    else $error("base word wrong");
  a_next_word: assert property ((s_next_cap ##1 (rd14 && an_complete && next_pages_supported))
    |=> hrdata == {16'h0000, $past(an_word, 2)}) else $error("next word wrong");
  a_pagerx_set: assert property (((an_word_valid && en_r) ##1 rd18) |=> hrdata == 32'h0000_0002)
    else $error("page flag not set");
  a_pagerx_clear: assert property ((rd18 && !an_word_valid ##1 !an_word_valid ##1 rd18) |=> hrdata == 32'h0000_0000)
    else $error("page flag not cleared");
  a_write_ignored: assert property ((rd14 && !an_word_valid ##1 !an_word_valid ##1 wr14 && !an_word_valid
    ##1 !an_word_valid ##1 rd14) |=> hrdata == $past(hrdata, 4)) else $error("write changed word");
  a_unmapped_zero: assert property ((rd && unm) |=> hrdata == 32'h0000_0000) else $error("unmapped not zero");
  a_reset_zero: assert property ((rd14 && !seen_r) |=> hrdata == 32'h0000_0000) else $error("word not zero");
endmodule : lpac_top_checker

bind lpac_top lpac_top_checker u_chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready, .hreadyout,
  .hresp, .hrdata, .hwdata, .an_word_valid, .an_word, .an_word_is_next, .an_complete, .next_pages_supported);

// ### link_partner_ability_capture_test.sv
module link_partner_ability_capture_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic hclk, hresetn, hsel, hwrite, an_complete, next_pages_supported, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  wire logic an_word_valid, an_word_is_next;
  wire logic [15:0] an_word;
  int n_fail = 0, num_checks = 0, cyc = 0;
  lpac_top u_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hburst(3'h0), .hprot(4'h0),
    .hready(hreadyout), .hwdata, .hreadyout, .hresp, .hrdata, .an_word_valid, .an_word, .an_word_is_next,
    .an_complete, .next_pages_supported);
  lpac_link_partner u_partner (.hclk, .an_word_valid, .an_word, .an_word_is_next);
  initial
  begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  // the whole run needs under a hundred cycles; a hang ends here at cycle 2000
  always @(posedge hclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 2000)
    begin
      n_fail++;
      test_done();
    end
  end
  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // single word transfer; ready is polled even though the slave never waits
  task bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask : bus
  task t_reset();
    bus(1'b0, 32'h14, 32'h0);
    chk("word after reset", rd, 32'h0);
    bus(1'b0, 32'h18, 32'h0);
    chk("page flag after reset", rd, 32'h0);
    $display("t_reset done");
  endtask : t_reset
  // every base field set and cleared; reserved bit must read zero
  task t_base();
    logic [15:0] tbl [4] = '{16'hffff, 16'h4001, 16'ha5b4, 16'h1fe0};
    foreach (tbl[i])
    begin
      u_partner.send(tbl[i], 1'b0);
      bus(1'b0, 32'h14, 32'h0);
      chk("base word", rd, {16'h0000, tbl[i] & 16'hefff});
      bus(1'b0, 32'h18, 32'h0);
      chk("page flag set", rd, 32'h2);
      bus(1'b0, 32'h18, 32'h0);
      chk("page flag clear", rd, 32'h0);
    end
    $display("t_base done");
  endtask : t_base
  task t_next();
    an_complete <= 1'b0;
    u_partner.send(16'hb7ff, 1'b1);
    bus(1'b0, 32'h14, 32'h0);
    chk("base before done", rd, 32'h0fe0);
    an_complete <= 1'b1;
    @(posedge hclk);
    bus(1'b0, 32'h14, 32'h0);
    chk("next word", rd, 32'hb7ff);
    u_partner.send(16'h4800, 1'b1);
    bus(1'b0, 32'h14, 32'h0);
    chk("second next word", rd, 32'h4800);
    next_pages_supported <= 1'b0;
    @(posedge hclk);
    bus(1'b0, 32'h14, 32'h0);
    chk("base without next pages", rd, 32'h0fe0);
    next_pages_supported <= 1'b1;
    $display("t_next done");
  endtask : t_next
  task t_write();
    bus(1'b0, 32'h14, 32'h0);
    bus(1'b1, 32'h14, 32'h0000_abfb);
    bus(1'b0, 32'h14, 32'h0);
    chk("word after write", rd, 32'h4800);
    bus(1'b1, 32'h3fc, 32'hffff_ffff);
    bus(1'b0, 32'h3fc, 32'h0);
    chk("unmapped read", rd, 32'h0);
    $display("t_write done");
  endtask : t_write
  // capture enable off drops words; status shows count, layout and held next page
  task t_ctrl();
    bus(1'b0, 32'h44, 32'h0);
    chk("status", rd, 32'h0000_0607);
    bus(1'b0, 32'h18, 32'h0);
    chk("page flag left set", rd, 32'h2);
    bus(1'b1, 32'h40, 32'h0);
    u_partner.send(16'h0021, 1'b0);
    bus(1'b0, 32'h44, 32'h0);
    chk("status capture off", rd, 32'h0000_0607);
    bus(1'b0, 32'h18, 32'h0);
    chk("page flag capture off", rd, 32'h0);
    bus(1'b0, 32'h14, 32'h0);
    chk("word capture off", rd, 32'h4800);
    bus(1'b0, 32'h40, 32'h0);
    chk("control off", rd, 32'h0);
    bus(1'b1, 32'h40, 32'h1);
    u_partner.send(16'h5421, 1'b0);
    bus(1'b0, 32'h18, 32'h0);
    chk("page flag at once", rd, 32'h2);
    bus(1'b0, 32'h14, 32'h0);
    chk("base after next", rd, 32'h4421);
    bus(1'b0, 32'h44, 32'h0);
    chk("status base again", rd, 32'h0000_0702);
    $display("t_ctrl done");
  endtask : t_ctrl
  // a reset in mid run clears every captured field and the count
  task t_midreset();
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, 32'h14, 32'h0);
    chk("word after mid reset", rd, 32'h0);
    bus(1'b0, 32'h44, 32'h0);
    chk("status after mid reset", rd, 32'h2);
    bus(1'b0, 32'h40, 32'h0);
    chk("control after mid reset", rd, 32'h1);
    $display("t_midreset done");
  endtask : t_midreset
  task test_done();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : test_done
  initial
  begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    an_complete = 1'b1;
    next_pages_supported = 1'b1;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_base();
    t_next();
    t_write();
    t_ctrl();
    t_midreset();
    test_done();
  end
endmodule : link_partner_ability_capture_test
